// >>> design/frps_pkg.sv
// Summary of operation
// - No access begins until 300 us have passed after both the core and I/O supplies are good.
// - Chip select stays high for at least 35 us after the restart pin is driven low.
// - The restart pin stays low at least 200 ns, and its low time plus high time before select covers the full restart interval.
// - Chip select stays high for at least 50 ns after the restart pin returns high.
// - Chip select stays high for at least 20 ns between two accesses.
// - Holding the restart pin low during power-up is optional, and the pulse limits still apply when it is used.
// - When restart is held during power-up, select waits for both supply waits and the restart interval to expire.
// - A restart held past the end of the supply wait has its restart interval counted from the end of that wait.
package frps_pkg;

	// Clock rate of core_clk in MHz.
	localparam int unsigned CLK_MHZ = 200;

	// Interval minima, in nanoseconds as printed.
	localparam int unsigned CORE_SUPPLY_WAIT_NS       = 300000;
	localparam int unsigned IO_SUPPLY_WAIT_NS         = 300000;
	localparam int unsigned RESTART_LOW_TO_SELECT_NS  = 35000;
	localparam int unsigned RESTART_PULSE_MIN_NS      = 200;
	localparam int unsigned RESTART_HIGH_TO_SELECT_NS = 50;
	localparam int unsigned SELECT_HIGH_MIN_NS        = 20;

	// A least time is rounded up to whole cycles, and never below one.
	function automatic int unsigned frps_min_cycles(input int unsigned ns);
		int unsigned c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c == 0) ? 1 : c;
	endfunction : frps_min_cycles

	// Both supply waits run together, so the longer one governs.
	localparam int unsigned SUPPLY_WAIT_CYC =
		(frps_min_cycles(CORE_SUPPLY_WAIT_NS) > frps_min_cycles(IO_SUPPLY_WAIT_NS)) ?
		frps_min_cycles(CORE_SUPPLY_WAIT_NS) : frps_min_cycles(IO_SUPPLY_WAIT_NS);
	localparam int unsigned RESTART_LOW_TO_SELECT_CYC  = frps_min_cycles(RESTART_LOW_TO_SELECT_NS);
	localparam int unsigned RESTART_PULSE_MIN_CYC      = frps_min_cycles(RESTART_PULSE_MIN_NS);
	localparam int unsigned RESTART_HIGH_TO_SELECT_CYC = frps_min_cycles(RESTART_HIGH_TO_SELECT_NS);
	localparam int unsigned SELECT_HIGH_MIN_CYC        = frps_min_cycles(SELECT_HIGH_MIN_NS);

	// Counter width that holds the longest count.
	localparam int unsigned CNT_W_DEF = 17;

	// Positions of the synchronised pin inputs.
	localparam int unsigned SYN_CORE = 0;
	localparam int unsigned SYN_IO   = 1;
	localparam int unsigned SYN_RB   = 2;

	// Sequencer states.
	typedef enum logic [2:0] {
		FRPS_OFF,
		FRPS_SUPPLY,
		FRPS_LOW,
		FRPS_HIGH,
		FRPS_READY
	} frps_state_t;

endpackage : frps_pkg

// >>> design/frps_tmr_if.sv
`timescale 1ns/1ps
// Load and expiry of one interval timer.
interface frps_tmr_if #(parameter int unsigned W = 17);
	logic         ce;
	logic         load;
	logic [W-1:0] value;
	logic         expired;

	modport ctl (output ce, output load, output value, input expired);
	modport tmr (input ce, input load, input value, output expired);
endinterface : frps_tmr_if

// >>> design/frps_timer.sv
`timescale 1ns/1ps
// Down counter: a load of N shows expired N enabled cycles later.
module frps_timer
	import frps_pkg::*;
#(
	parameter int unsigned W = CNT_W_DEF
)(
	input wire logic core_clk,
	input wire logic rst,
	frps_tmr_if.tmr  t
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} frps_tmr_state_t;

	frps_tmr_state_t r;
	frps_tmr_state_t nxt;

	////////////////////////////////////////////////////////////////////////
	// Next count; a load wins over the running decrement.
	always_comb
	begin
		nxt = r;
		if (t.ce)
		begin
			if (t.load)
				nxt.cnt = t.value;
			else if (r.cnt != '0)
				nxt.cnt = r.cnt - W'(1);
		end
	end

	// Reset leaves the timer expired so nothing waits on a dead count.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= nxt;
	end

	assign t.expired = (r.cnt == '0);

	////////////////////////////////////////////////////////////////////////
	a_timer_load: assert property (@(posedge core_clk) disable iff (rst)
		t.ce && t.load |=> r.cnt == $past(t.value))
		else $error("timer did not take its load value");

	a_timer_freeze: assert property (@(posedge core_clk) disable iff (rst)
		!t.ce |=> $stable(r.cnt))
		else $error("timer moved while clock enable was low");

endmodule : frps_timer

// >>> design/frps_sequencer.sv
`timescale 1ns/1ps
// Host sequencer for the flash power-up wait, restart pulse and first select.
module frps_sequencer
	import frps_pkg::*;
#(
	parameter int unsigned CNT_W      = CNT_W_DEF,
	parameter int unsigned SUPPLY_CYC = SUPPLY_WAIT_CYC,
	parameter int unsigned RPH_CYC    = RESTART_LOW_TO_SELECT_CYC
)(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	input  wire logic core_supply_ok,
	input  wire logic io_supply_ok,
	input  wire logic ready_busy_n,
	input  wire logic hold_restart_at_power,
	input  wire logic restart_req,
	input  wire logic access_req,
	output logic      restart_n,
	output logic      chip_select_n,
	output logic      seq_done,
	output logic      flash_ready
);

	// Low time that also leaves the full restart interval covered after release.
	localparam int unsigned LOW_CYC =
		(RESTART_PULSE_MIN_CYC > RPH_CYC - RESTART_HIGH_TO_SELECT_CYC) ?
		RESTART_PULSE_MIN_CYC : RPH_CYC - RESTART_HIGH_TO_SELECT_CYC;

	////////////////////////////////////////////////////////////////////////
	// Refuse sizes the counters cannot hold.
	if (SUPPLY_CYC >= (1 << CNT_W) || RPH_CYC >= (1 << CNT_W) || CNT_W > 30)
	begin : g_bad_width
		$error("CNT_W too small for the interval counts");
	end
	if (RPH_CYC <= RESTART_HIGH_TO_SELECT_CYC)
	begin : g_bad_rph
		$error("RPH_CYC must exceed the restart high time");
	end

	typedef struct packed {
		frps_state_t state;
		logic [2:0]  sync1;
		logic [2:0]  sync2;
		logic        restart_n;
		logic        cs_n;
		logic        done;
	} frps_seq_state_t;

	frps_seq_state_t r;
	frps_seq_state_t nxt;

	frps_tmr_if #(.W(CNT_W)) seq_t ();
	frps_tmr_if #(.W(CNT_W)) gap_t ();

	logic sup_ok;
	logic rb_high;

	////////////////////////////////////////////////////////////////////////
	// Interval timers: one for the sequence, one for the select gap.
	frps_timer #(.W(CNT_W)) u_seq_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.t        (seq_t.tmr)
	);

	frps_timer #(.W(CNT_W)) u_gap_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.t        (gap_t.tmr)
	);

	assign seq_t.ce = clk_en;
	assign gap_t.ce = clk_en;

	// Only the second synchroniser stage is ever decoded.
	assign sup_ok  = r.sync2[SYN_CORE] & r.sync2[SYN_IO];
	assign rb_high = r.sync2[SYN_RB];

	////////////////////////////////////////////////////////////////////////
	// Sequencer; a supply loss from any state starts the whole wait over.
	always_comb
	begin
		nxt         = r;
		seq_t.load  = 1'b0;
		seq_t.value = '0;
		gap_t.load  = 1'b0;
		gap_t.value = '0;
		if (clk_en)
		begin
			nxt.sync1 = {ready_busy_n, io_supply_ok, core_supply_ok};
			nxt.sync2 = r.sync1;
			if (!sup_ok)
			begin
				// Optional hold during power-up; its limits are met after the wait.
				nxt.state     = FRPS_OFF;
				nxt.restart_n = ~hold_restart_at_power;
				nxt.cs_n      = 1'b1;
				nxt.done      = 1'b0;
			end
			else
			begin
				unique case (r.state)
					FRPS_OFF:
					begin
						seq_t.load  = 1'b1;
						seq_t.value = CNT_W'(SUPPLY_CYC);
						nxt.state   = FRPS_SUPPLY;
					end
					FRPS_SUPPLY:
					begin
						if (seq_t.expired)
						begin
							if (!r.restart_n)
							begin
								// Restart interval counted from the end of the wait.
								seq_t.load  = 1'b1;
								seq_t.value = CNT_W'(LOW_CYC);
								nxt.state   = FRPS_LOW;
							end
							else
							begin
								nxt.state = FRPS_READY;
								nxt.done  = 1'b1;
							end
						end
					end
					FRPS_LOW:
					begin
						if (seq_t.expired)
						begin
							nxt.restart_n = 1'b1;
							seq_t.load    = 1'b1;
							seq_t.value   = CNT_W'(RESTART_HIGH_TO_SELECT_CYC);
							nxt.state     = FRPS_HIGH;
						end
					end
					FRPS_HIGH:
					begin
						if (seq_t.expired)
						begin
							nxt.state = FRPS_READY;
							nxt.done  = 1'b1;
						end
					end
					FRPS_READY:
					begin
						if (restart_req)
						begin
							// Warm restart aborts any access; select goes high at once.
							nxt.restart_n = 1'b0;
							nxt.cs_n      = 1'b1;
							nxt.done      = 1'b0;
							seq_t.load    = 1'b1;
							seq_t.value   = CNT_W'(LOW_CYC);
							nxt.state     = FRPS_LOW;
							if (!r.cs_n)
							begin
								gap_t.load  = 1'b1;
								gap_t.value = CNT_W'(SELECT_HIGH_MIN_CYC);
							end
						end
						else if (!r.cs_n && !access_req)
						begin
							nxt.cs_n    = 1'b1;
							gap_t.load  = 1'b1;
							gap_t.value = CNT_W'(SELECT_HIGH_MIN_CYC);
						end
						else if (r.cs_n && access_req && gap_t.expired)
							nxt.cs_n = 1'b0;
					end
				endcase
			end
		end
	end

	// All control state starts idle with restart released and select high.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			r           <= '0;
			r.state     <= FRPS_OFF;
			r.restart_n <= 1'b1;
			r.cs_n      <= 1'b1;
		end
		else
			r <= nxt;
	end

	assign restart_n     = r.restart_n;
	assign chip_select_n = r.cs_n;
	assign seq_done      = r.done;
	assign flash_ready   = r.done & rb_high;

	////////////////////////////////////////////////////////////////////////
	// Helper counters read only by the checks below.
	function automatic logic [CNT_W-1:0] frps_sat_inc(input logic [CNT_W-1:0] v);
		return (v == '1) ? v : v + CNT_W'(1);
	endfunction : frps_sat_inc

	logic [CNT_W-1:0] h_sup_len;
	logic [CNT_W-1:0] h_low_len;
	logic [CNT_W-1:0] h_high_len;
	logic [CNT_W-1:0] h_cs_high;
	logic [CNT_W-1:0] h_low_after;
	logic             h_ever_low;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			h_sup_len   <= '0;
			h_low_len   <= '0;
			h_high_len  <= '0;
			h_cs_high   <= '0;
			h_low_after <= '0;
			h_ever_low  <= 1'b0;
		end
		else if (clk_en)
		begin
			h_sup_len   <= sup_ok ? frps_sat_inc(h_sup_len) : '0;
			h_low_len   <= nxt.restart_n ? '0 : frps_sat_inc(h_low_len);
			h_high_len  <= nxt.restart_n ? frps_sat_inc(h_high_len) : '0;
			h_cs_high   <= nxt.cs_n ? frps_sat_inc(h_cs_high) : '0;
			// Low time since the wait ended; it is kept after release for the select check.
			if (r.state == FRPS_SUPPLY)
				h_low_after <= '0;
			else if (!nxt.restart_n)
				h_low_after <= r.restart_n ? CNT_W'(1) : frps_sat_inc(h_low_after);
			if (!nxt.restart_n)
				h_ever_low <= 1'b1;
		end
	end

	a_select_after_supply: assert property (@(posedge core_clk) disable iff (rst)
		$fell(chip_select_n) |-> h_sup_len >= CNT_W'(SUPPLY_CYC))
		else $error("select low before supply wait elapsed");

	a_low_to_select: assert property (@(posedge core_clk) disable iff (rst)
		$fell(chip_select_n) && h_ever_low |->
		{1'b0, h_high_len} + {1'b0, h_low_after} >= {1'b0, CNT_W'(RPH_CYC)})
		else $error("select low too soon after restart low");

	a_pulse_width: assert property (@(posedge core_clk) disable iff (rst)
		$rose(restart_n) |-> $past(h_low_len) >= CNT_W'(RESTART_PULSE_MIN_CYC))
		else $error("restart pulse too short");

	a_high_to_select: assert property (@(posedge core_clk) disable iff (rst)
		$fell(chip_select_n) |-> h_high_len >= CNT_W'(RESTART_HIGH_TO_SELECT_CYC))
		else $error("select low too soon after restart high");

	a_select_gap: assert property (@(posedge core_clk) disable iff (rst)
		$fell(chip_select_n) |-> $past(h_cs_high) >= CNT_W'(SELECT_HIGH_MIN_CYC))
		else $error("select high gap too short");

	a_quiet_until_done: assert property (@(posedge core_clk) disable iff (rst)
		!seq_done |-> chip_select_n)
		else $error("select low before sequence done");

	a_count_from_wait: assert property (@(posedge core_clk) disable iff (rst)
		$rose(restart_n) && r.state == FRPS_HIGH && sup_ok
		|-> $past(h_low_after) >= CNT_W'(LOW_CYC - 1))
		else $error("restart released before interval from wait end");

	a_ready_qualified: assert property (@(posedge core_clk) disable iff (rst)
		flash_ready && $past(clk_en) && $past(clk_en, 2) |-> seq_done && $past(ready_busy_n, 2))
		else $error("ready shown without done and ready/busy high");

	a_done_restart_high: assert property (@(posedge core_clk) disable iff (rst)
		seq_done |-> restart_n && h_high_len >= CNT_W'(RESTART_HIGH_TO_SELECT_CYC))
		else $error("done shown while restart not settled");

endmodule : frps_sequencer

// >>> dv/frps_flash_model.sv
`timescale 1ns/1ps
// Behavioural flash: cold reset after supply, warm reset on restart.
module frps_flash_model #(
	parameter int unsigned COLD = 50,
	parameter int unsigned WARM = 60
)(
	input  wire logic core_clk,
	input  wire logic supply_ok,
	input  wire logic restart_n,
	input  wire logic chip_select_n,
	input  wire logic slow,
	output logic      ready_busy_n,
	output logic      viol
);
	int   cold_r;
	int   warm_r;
	logic rn_r;
	logic busy;
	// A held restart at the end of cold reset starts its interval there.
	always_ff @(posedge core_clk)
	begin
		rn_r <= restart_n;
		if (!supply_ok) cold_r <= COLD;
		else if (cold_r != 0) cold_r <= cold_r - 1;
		if (cold_r != 0) warm_r <= restart_n ? 0 : WARM;
		else if (rn_r && !restart_n) warm_r <= WARM;
		else if (warm_r != 0) warm_r <= warm_r - 1;
	end
	// Slow stands for a long embedded operation the bench asks for.
	assign busy = (cold_r != 0) || (warm_r != 0) || !restart_n || slow;
	assign ready_busy_n = !busy;
	assign viol = !chip_select_n && busy;
endmodule : frps_flash_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
// Bench for the flash power-up and restart sequencer.
module tb_top;
	import frps_pkg::*;
	localparam int unsigned SUP = 50;
	localparam int unsigned RPH = 60;
	logic core_clk, rst, clk_en, core_supply_ok, io_supply_ok, ready_busy_n;
	logic hold_restart_at_power, restart_req, access_req, slow, viol;
	logic restart_n, chip_select_n, seq_done, flash_ready;
	int   failures, num_checks, cyc, hi_run, n, f;

	frps_sequencer #(.SUPPLY_CYC(SUP), .RPH_CYC(RPH)) dut (
		.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.core_supply_ok(core_supply_ok), .io_supply_ok(io_supply_ok),
		.ready_busy_n(ready_busy_n), .hold_restart_at_power(hold_restart_at_power),
		.restart_req(restart_req), .access_req(access_req), .restart_n(restart_n),
		.chip_select_n(chip_select_n), .seq_done(seq_done), .flash_ready(flash_ready));
	frps_flash_model #(.COLD(SUP), .WARM(RPH)) flash (
		.core_clk(core_clk), .supply_ok(core_supply_ok & io_supply_ok),
		.restart_n(restart_n), .chip_select_n(chip_select_n), .slow(slow),
		.ready_busy_n(ready_busy_n), .viol(viol));

	////////////////////////////////////////////////////////////////////////
	// Restart low time: the larger of the pulse minimum and the interval less the high time, plus one cycle.
	function automatic int low_len();
		int d;
		d = RPH - RESTART_HIGH_TO_SELECT_CYC;
		return ((d > RESTART_PULSE_MIN_CYC) ? d : RESTART_PULSE_MIN_CYC) + 1;
	endfunction : low_len

	task automatic step();
		@(posedge core_clk);
		#1;
	endtask : step

	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s: expected %b, seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		num_checks++;
		if (got < lo || got > hi)
		begin
			failures++;
			$display("wrong value %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
		end
	endtask : chk_rng

	// Bounded wait, so a stuck output ends in a mismatch, not a hang.
	task automatic wait_for(ref logic s, input logic v, output int k);
		k = 0;
		while (s !== v && k < 2000)
		begin
			step();
			k++;
		end
	endtask : wait_for

	task automatic wrap_up();
		$display("checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	// Clock, timeout and the watch on select gaps and flash busy time.
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			wrap_up();
		end
		if (viol === 1'b1) chk_bit("select while busy", 1'b0, viol);
		if (chip_select_n === 1'b0 && hi_run > 0)
			chk_rng("gap", SELECT_HIGH_MIN_CYC + 1, 99999, hi_run);
		hi_run = (chip_select_n === 1'b1) ? hi_run + 1 : 0;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence: power-up, accesses, restarts, busy, held restart.
	initial
	begin
		rst = 1'b1;
		clk_en = 1'b1;
		core_supply_ok = 1'b0;
		io_supply_ok = 1'b0;
		hold_restart_at_power = 1'b0;
		restart_req = 1'b0;
		access_req = 1'b0;
		slow = 1'b0;
		void'($urandom(22));
		repeat (10) @(posedge core_clk);
		#1 rst = 1'b0;
		chk_bit("restart after reset", 1'b1, restart_n);
		chk_bit("done after reset", 1'b0, seq_done);
		access_req = 1'b1;
		core_supply_ok = 1'b1;
		repeat ($urandom_range(1, 9)) step();
		io_supply_ok = 1'b1;
		wait_for(seq_done, 1'b1, n);
		chk_rng("supply wait", SUP, SUP + 5, n);
		wait_for(chip_select_n, 1'b0, n);
		chk_rng("first select", 0, 1, n);
		repeat (12)
		begin
			repeat ($urandom_range(1, 6)) step();
			access_req = 1'b0;
			step();
			chk_bit("select release", 1'b1, chip_select_n);
			access_req = 1'b1;
			wait_for(chip_select_n, 1'b0, n);
			chk_rng("select retry", SELECT_HIGH_MIN_CYC, SELECT_HIGH_MIN_CYC + 1, n);
		end
		// Back-to-back restarts with access held; the second is frozen a while.
		for (int i = 0; i < 2; i++)
		begin
			f = i * $urandom_range(3, 20);
			restart_req = 1'b1;
			step();
			restart_req = 1'b0;
			chk_bit("restart taken", 1'b0, restart_n);
			if (f != 0)
			begin
				clk_en = 1'b0;
				repeat (f) step();
				clk_en = 1'b1;
			end
			wait_for(restart_n, 1'b1, n);
			// Frozen cycles still count toward the low time seen by the flash.
			chk_rng("restart low", low_len() + f, low_len() + f, n + f);
			wait_for(seq_done, 1'b1, n);
			chk_rng("high to done", RESTART_HIGH_TO_SELECT_CYC + 1,
				RESTART_HIGH_TO_SELECT_CYC + 1, n);
		end
		// Select after a warm restart, so the restart-to-select check has work.
		wait_for(chip_select_n, 1'b0, n);
		chk_rng("select after restart", 1, 1, n);
		access_req = 1'b0;
		repeat (3) step();
		chk_bit("ready", 1'b1, flash_ready);
		slow = 1'b1;
		repeat (3) step();
		chk_bit("ready while busy", 1'b0, flash_ready);
		slow = 1'b0;
		repeat (3) step();
		chk_bit("ready again", 1'b1, flash_ready);
		hold_restart_at_power = 1'b1;
		io_supply_ok = 1'b0;
		repeat (5) step();
		chk_bit("done after loss", 1'b0, seq_done);
		chk_bit("restart held", 1'b0, restart_n);
		io_supply_ok = 1'b1;
		wait_for(restart_n, 1'b1, n);
		chk_rng("held restart", SUP + low_len(), SUP + low_len() + 5, n);
		wait_for(seq_done, 1'b1, n);
		chk_rng("held done", RESTART_HIGH_TO_SELECT_CYC + 1,
			RESTART_HIGH_TO_SELECT_CYC + 1, n);
		wrap_up();
	end
endmodule : tb_top
